// [src/ovpc_pkg.sv]
// Purpose: shared constants and types for the oven panel controller
// Assumes: 40 MHz ref_clk
// Notes: times are given in their own unit, cycle counts derive from them
package ovpc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // periodic tick from the compare timer
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam logic [15:0] TICK_CYCLES = 16'(TICK_PERIOD_NS / CLK_PERIOD_NS);
  // fixed unit of the random sampling delay
  localparam int unsigned RND_UNIT_NS = 50000;
  localparam logic [12:0] RND_UNIT_CYCLES = 13'(RND_UNIT_NS / CLK_PERIOD_NS);
  // longest quiet time on the ac line before it counts as lost
  localparam int unsigned AC_TIMEOUT_NS = 25000000;
  localparam logic [22:0] AC_TIMEOUT_CYCLES = 23'(AC_TIMEOUT_NS / CLK_PERIOD_NS);

  // interval thresholds, in ticks
  localparam logic [15:0] SCAN_TICKS = 16'h000a;
  localparam logic [15:0] ADC_TICKS = 16'h0064;
  localparam logic [15:0] SMP_TICKS = 16'h0005;
  localparam logic [15:0] MSG_HOLD_TICKS = 16'h03e8;
  localparam logic [15:0] ADC_TIMEOUT_TICKS = 16'h000a;
  localparam int unsigned NUM_IVL = 3;
  localparam int unsigned IVL_SCAN = 0;
  localparam int unsigned IVL_ADC = 1;
  localparam int unsigned IVL_SMP = 2;

  // touch keys
  localparam int unsigned NUM_KEYS = 16;
  localparam logic [3:0] KEY_MODE = 4'h8;
  localparam logic [3:0] KEY_START = 4'h9;
  localparam logic [3:0] KEY_STOP = 4'ha;
  localparam logic [3:0] LAST_CHAN = 4'hf;
  // equal reads needed, minus one
  localparam logic [1:0] CONFIRM_CNT = 2'h2;

  // operating mode, 0 is mode 1
  localparam logic [1:0] MODE_RESET = 2'h0;

  // temperature scaling
  localparam logic [7:0] TEMP_GAIN = 8'hc0;
  localparam int unsigned TEMP_SHIFT = 8;
  localparam logic [9:0] TEMP_MAX = 10'h3e7;

  // segment patterns, bit order g f e d c b a
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_DIGIT [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                                            7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  localparam logic [6:0] SEG_UA = 7'h77;
  localparam logic [6:0] SEG_UC = 7'h39;
  localparam logic [6:0] SEG_LD = 7'h5e;
  localparam logic [6:0] SEG_UE = 7'h79;
  localparam logic [6:0] SEG_LE = 7'h7b;
  localparam logic [6:0] SEG_LL = 7'h30;
  localparam logic [6:0] SEG_LN = 7'h54;
  localparam logic [6:0] SEG_LO = 7'h5c;
  localparam logic [6:0] SEG_UO = 7'h3f;
  localparam logic [6:0] SEG_UP = 7'h73;
  localparam logic [6:0] SEG_LR = 7'h50;
  localparam logic [6:0] SEG_US = 7'h6d;
  localparam logic [6:0] SEG_UT = 7'h31;

  typedef enum logic [1:0] {ST_STOPPED, ST_RUNNING, ST_LOCKED} ovpc_state_t;
  typedef enum logic [3:0] {
    MSG_NORMAL, MSG_DIGITS, MSG_MODE, MSG_START, MSG_STOP, MSG_NOT_ALLOWED,
    MSG_ERROR, MSG_AC_ERROR, MSG_ADC_ERROR, MSG_OPEN
  } ovpc_msg_t;
endpackage

// [src/ovpc_sampler.sv]
// Purpose: random-delayed, repeat-confirmed sampling of one input
// Assumes: raw is already synchronised
// Notes: a request during the delay is dropped, the next one follows
module ovpc_sampler #(
  parameter logic [12:0] RND_UNIT = ovpc_pkg::RND_UNIT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // sampling link
  ovpc_smp_if.smp smp
);
  typedef enum logic {SP_IDLE, SP_WAIT} ovpc_sphase_t;
  typedef struct packed {
    ovpc_sphase_t phase;
    logic [12:0] dly;
    logic cand;
    logic [1:0] cnt;
    logic stable;
  } ovpc_smp_st_t;

  ovpc_smp_st_t st_r;
  ovpc_smp_st_t st_nxt;

  assign smp.stable = st_r.stable;

  // delay then read, accept only after repeated equal reads
  always_comb begin
    st_nxt = st_r;
    case (st_r.phase)
      SP_IDLE: begin
        if (smp.smp_req) begin
          st_nxt.dly = 13'({11'h000, smp.rnd} * RND_UNIT);
          st_nxt.phase = SP_WAIT;
        end
      end
      default: begin
        if (st_r.dly == 13'h0000) begin
          st_nxt.phase = SP_IDLE;
          if (smp.raw == st_r.cand) begin
            if (st_r.cnt == ovpc_pkg::CONFIRM_CNT) begin
              st_nxt.stable = st_r.cand;
            end else begin
              st_nxt.cnt = st_r.cnt + 2'h1;
            end
          end else begin
            st_nxt.cand = smp.raw;
            st_nxt.cnt = 2'h0;
          end
        end else begin
          st_nxt.dly = st_r.dly - 13'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// [src/ovpc_smp_if.sv]
// Purpose: carries the door sampling request and result
// Assumes: both ends on ref_clk
// Notes: rnd is taken at the request
interface ovpc_smp_if;
  logic smp_req;
  logic [1:0] rnd;
  logic raw;
  logic stable;
  modport host (output smp_req, output rnd, output raw, input stable);
  modport smp (input smp_req, input rnd, input raw, output stable);
endinterface

// [src/ovpc_top.sv]
// Purpose: oven front panel and power sequencing controller
// Assumes: touch block and adc are on ref_clk; door and ac line are pins
// Notes: mode 1 is held as code 0
module ovpc_top #(
  parameter logic [15:0] TICK_CYC = ovpc_pkg::TICK_CYCLES,
  parameter logic [12:0] RND_UNIT_CYC = ovpc_pkg::RND_UNIT_CYCLES,
  parameter logic [22:0] AC_TIMEOUT_CYC = ovpc_pkg::AC_TIMEOUT_CYCLES,
  parameter logic [15:0] SCAN_THR = ovpc_pkg::SCAN_TICKS,
  parameter logic [15:0] ADC_THR = ovpc_pkg::ADC_TICKS,
  parameter logic [15:0] SMP_THR = ovpc_pkg::SMP_TICKS,
  parameter logic [15:0] HOLD_TICKS = ovpc_pkg::MSG_HOLD_TICKS,
  parameter logic [15:0] ADC_TO_TICKS = ovpc_pkg::ADC_TIMEOUT_TICKS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // touch_sense_input scanning
  input wire logic touch_meas_done,
  input wire logic touch_hit,
  output logic [3:0] touch_chan,
  output logic touch_start,
  // door switch and ac line pins
  input wire logic door_open_in,
  input wire logic ac_line_in,
  // temperature conversion
  input wire logic adc_done,
  input wire logic [9:0] adc_data,
  output logic adc_start,
  // power stages
  output logic fan_en,
  output logic grill_en,
  output logic micro_en,
  // display, leftmost digit in the top bits
  output logic [27:0] disp_seg,
  // status
  output logic run_active,
  output logic ac_error,
  output logic adc_error,
  output logic [22:0] line_period,
  output logic [15:0] line_clock,
  output logic [9:0] temp_value
);
  typedef struct packed {
    logic door_s1, door_s2, ac_s1, ac_s2, ac_s3;
    logic [15:0] frc;
    logic [15:0] tick_cnt;
    logic [ovpc_pkg::NUM_IVL-1:0][15:0] ivl;
    logic smp_req;
    logic [3:0] chan;
    logic scanning, touch_start;
    logic [ovpc_pkg::NUM_KEYS-1:0] hit;
    logic [ovpc_pkg::NUM_KEYS-1:0][1:0] kcnt;
    logic [ovpc_pkg::NUM_KEYS-1:0] kconf;
    logic [1:0] mode;
    ovpc_pkg::ovpc_state_t st;
    ovpc_pkg::ovpc_msg_t evt;
    logic [15:0] hold;
    logic [22:0] ac_cnt, line_period;
    logic [15:0] line_clock;
    logic ac_err;
    logic adc_busy, adc_start, adc_err, calc;
    logic [15:0] adc_wait;
    logic [9:0] sample, temp;
    logic fan, grill, micro, run;
    logic [27:0] seg;
  } ovpc_top_st_t;

  ovpc_top_st_t st_r;
  ovpc_top_st_t st_nxt;
  ovpc_smp_if smp ();

  // interval step: {hit, next count}
  function automatic logic [16:0] ivl_step(input logic [15:0] c, input logic [15:0] thr);
    if (c == thr - 16'h0001) begin
      ivl_step = {1'b1, 16'h0000};
    end else begin
      ivl_step = {1'b0, c + 16'h0001};
    end
  endfunction

  function automatic logic [6:0] digit_seg(input logic [3:0] d);
    if (d < 4'ha) begin
      digit_seg = ovpc_pkg::SEG_DIGIT[d];
    end else begin
      digit_seg = ovpc_pkg::SEG_BLANK;
    end
  endfunction

  // message to four digit patterns
  function automatic logic [27:0] msg_segs(input ovpc_pkg::ovpc_msg_t m, input logic [1:0] md,
                                           input logic [9:0] t);
    logic [3:0] h;
    logic [3:0] te;
    logic [3:0] o;
    h = 4'(t / 10'd100);
    te = 4'((t / 10'd10) % 10'd10);
    o = 4'(t % 10'd10);
    case (m)
      ovpc_pkg::MSG_DIGITS: msg_segs = {ovpc_pkg::SEG_BLANK, digit_seg(h), digit_seg(te),
                                        digit_seg(o)};
      ovpc_pkg::MSG_MODE: msg_segs = {ovpc_pkg::SEG_UO, ovpc_pkg::SEG_UP, ovpc_pkg::SEG_UT,
                                      digit_seg({2'h0, md} + 4'h1)};
      ovpc_pkg::MSG_START: msg_segs = {ovpc_pkg::SEG_US, ovpc_pkg::SEG_UT, ovpc_pkg::SEG_UA,
                                       ovpc_pkg::SEG_LR};
      ovpc_pkg::MSG_STOP: msg_segs = {ovpc_pkg::SEG_US, ovpc_pkg::SEG_UT, ovpc_pkg::SEG_UO,
                                      ovpc_pkg::SEG_UP};
      ovpc_pkg::MSG_NOT_ALLOWED: msg_segs = {ovpc_pkg::SEG_LN, ovpc_pkg::SEG_LO,
                                             ovpc_pkg::SEG_UT, ovpc_pkg::SEG_UA};
      ovpc_pkg::MSG_ERROR: msg_segs = {ovpc_pkg::SEG_LE, ovpc_pkg::SEG_LR, ovpc_pkg::SEG_LO,
                                       ovpc_pkg::SEG_LR};
      ovpc_pkg::MSG_AC_ERROR: msg_segs = {ovpc_pkg::SEG_UA, ovpc_pkg::SEG_UC, ovpc_pkg::SEG_LE,
                                          ovpc_pkg::SEG_LR};
      ovpc_pkg::MSG_ADC_ERROR: msg_segs = {ovpc_pkg::SEG_UA, ovpc_pkg::SEG_LD, ovpc_pkg::SEG_LE,
                                           ovpc_pkg::SEG_LR};
      ovpc_pkg::MSG_OPEN: msg_segs = {ovpc_pkg::SEG_UO, ovpc_pkg::SEG_UP, ovpc_pkg::SEG_UE,
                                      ovpc_pkg::SEG_LN};
      default: msg_segs = {ovpc_pkg::SEG_LN, ovpc_pkg::SEG_LO, ovpc_pkg::SEG_LR,
                           ovpc_pkg::SEG_LL};
    endcase
  endfunction

  // door is sampled with a random delay and confirmed by repeated reads
  ovpc_sampler #(.RND_UNIT(RND_UNIT_CYC)) u_door_smp (
    .ref_clk(ref_clk),
    .reset(reset),
    .smp(smp.smp)
  );
  assign smp.smp_req = st_r.smp_req;
  assign smp.rnd = st_r.frc[1:0];
  assign smp.raw = st_r.door_s2;

  // outputs, all from the state register
  assign touch_chan = st_r.chan;
  assign touch_start = st_r.touch_start;
  assign adc_start = st_r.adc_start;
  assign fan_en = st_r.fan;
  assign grill_en = st_r.grill;
  assign micro_en = st_r.micro;
  assign disp_seg = st_r.seg;
  assign run_active = st_r.run;
  assign ac_error = st_r.ac_err;
  assign adc_error = st_r.adc_err;
  assign line_period = st_r.line_period;
  assign line_clock = st_r.line_clock;
  assign temp_value = st_r.temp;

  // whole next-state computation
  always_comb begin
    logic tick;
    logic [ovpc_pkg::NUM_IVL-1:0] ihit;
    logic [ovpc_pkg::NUM_IVL-1:0][15:0] thr;
    logic [16:0] step;
    logic zc;
    logic door;
    logic fault;
    logic kill;
    logic p_mode;
    logic p_start;
    logic p_stop;
    logic [2:0] tgt;
    logic [17:0] prod;
    ovpc_pkg::ovpc_msg_t msg;
    tick = 1'b0;
    ihit = '0;
    thr = '0;
    step = '0;
    zc = 1'b0;
    door = 1'b0;
    fault = 1'b0;
    kill = 1'b0;
    p_mode = 1'b0;
    p_start = 1'b0;
    p_stop = 1'b0;
    tgt = 3'h0;
    prod = '0;
    msg = ovpc_pkg::MSG_NORMAL;
    st_nxt = st_r;

    // pin synchronisers, third ac stage only for edge detection
    st_nxt.door_s1 = door_open_in;
    st_nxt.door_s2 = st_r.door_s1;
    st_nxt.ac_s1 = ac_line_in;
    st_nxt.ac_s2 = st_r.ac_s1;
    st_nxt.ac_s3 = st_r.ac_s2;
    st_nxt.frc = st_r.frc + 16'h0001;

    // periodic tick and the interval counters it clocks
    tick = (st_r.tick_cnt == TICK_CYC - 16'h0001);
    st_nxt.tick_cnt = tick ? 16'h0000 : st_r.tick_cnt + 16'h0001;
    thr[ovpc_pkg::IVL_SCAN] = SCAN_THR;
    thr[ovpc_pkg::IVL_ADC] = ADC_THR;
    thr[ovpc_pkg::IVL_SMP] = SMP_THR;
    for (int i = 0; i < ovpc_pkg::NUM_IVL; i++) begin
      step = ivl_step(st_r.ivl[i], thr[i]);
      if (tick) begin
        st_nxt.ivl[i] = step[15:0];
        ihit[i] = step[16];
      end
    end
    st_nxt.smp_req = ihit[ovpc_pkg::IVL_SMP];
    door = smp.stable;

    // ac line: period, line clock, zero-cross, loss timeout
    zc = st_r.ac_s2 ^ st_r.ac_s3;
    if (zc) begin
      st_nxt.line_period = st_r.ac_cnt;
      st_nxt.ac_cnt = 23'h000001;
      st_nxt.line_clock = st_r.line_clock + 16'h0001;
      st_nxt.ac_err = 1'b0;
    end else if (st_r.ac_cnt == AC_TIMEOUT_CYC) begin
      st_nxt.ac_err = 1'b1;
    end else begin
      st_nxt.ac_cnt = st_r.ac_cnt + 23'h000001;
    end

    // touch channel scan, one channel at a time
    st_nxt.touch_start = 1'b0;
    if (!st_r.scanning && ihit[ovpc_pkg::IVL_SCAN]) begin
      st_nxt.scanning = 1'b1;
      st_nxt.chan = 4'h0;
      st_nxt.touch_start = 1'b1;
    end else if (st_r.scanning && touch_meas_done) begin
      st_nxt.hit[st_r.chan] = touch_hit;
      if (st_r.chan == ovpc_pkg::LAST_CHAN) begin
        st_nxt.scanning = 1'b0;
      end else begin
        st_nxt.chan = st_r.chan + 4'h1;
        st_nxt.touch_start = 1'b1;
      end
    end
    // after a full scan each key needs repeated equal reads
    if (st_r.scanning && !st_nxt.scanning) begin
      for (int k = 0; k < ovpc_pkg::NUM_KEYS; k++) begin
        if (st_nxt.hit[k] == st_r.kconf[k]) begin
          st_nxt.kcnt[k] = 2'h0;
        end else if (st_r.kcnt[k] == ovpc_pkg::CONFIRM_CNT) begin
          st_nxt.kconf[k] = st_nxt.hit[k];
          st_nxt.kcnt[k] = 2'h0;
        end else begin
          st_nxt.kcnt[k] = st_r.kcnt[k] + 2'h1;
        end
      end
    end
    // only these three keys are decoded; the rest stay silent
    p_mode = st_nxt.kconf[ovpc_pkg::KEY_MODE] & ~st_r.kconf[ovpc_pkg::KEY_MODE];
    p_start = st_nxt.kconf[ovpc_pkg::KEY_START] & ~st_r.kconf[ovpc_pkg::KEY_START];
    p_stop = st_nxt.kconf[ovpc_pkg::KEY_STOP] & ~st_r.kconf[ovpc_pkg::KEY_STOP];

    // temperature conversion, with a timeout so a dead adc is flagged
    st_nxt.adc_start = 1'b0;
    st_nxt.calc = 1'b0;
    if (!st_r.adc_busy && ihit[ovpc_pkg::IVL_ADC]) begin
      st_nxt.adc_start = 1'b1;
      st_nxt.adc_busy = 1'b1;
      st_nxt.adc_wait = 16'h0000;
    end else if (st_r.adc_busy && adc_done) begin
      st_nxt.sample = adc_data;
      st_nxt.calc = 1'b1;
      st_nxt.adc_busy = 1'b0;
      st_nxt.adc_err = 1'b0;
    end else if (st_r.adc_busy && tick) begin
      if (st_r.adc_wait == ADC_TO_TICKS) begin
        st_nxt.adc_err = 1'b1;
        st_nxt.adc_busy = 1'b0;
      end else begin
        st_nxt.adc_wait = st_r.adc_wait + 16'h0001;
      end
    end
    if (st_r.calc) begin
      prod = {8'h00, st_r.sample} * {10'h000, ovpc_pkg::TEMP_GAIN};
      st_nxt.temp = (prod[17:ovpc_pkg::TEMP_SHIFT] > ovpc_pkg::TEMP_MAX) ?
                    ovpc_pkg::TEMP_MAX : prod[17:ovpc_pkg::TEMP_SHIFT];
    end

    // message hold timer
    if (tick && st_r.hold != 16'h0000) begin
      st_nxt.hold = st_r.hold - 16'h0001;
    end

    // operating flow
    fault = st_r.ac_err | st_r.adc_err;
    case (st_r.st)
      ovpc_pkg::ST_STOPPED: begin
        if (p_mode) begin
          st_nxt.mode = st_r.mode + 2'h1;
          st_nxt.evt = ovpc_pkg::MSG_MODE;
          st_nxt.hold = HOLD_TICKS;
        end else if (p_start && (door || fault)) begin
          st_nxt.evt = ovpc_pkg::MSG_NOT_ALLOWED;
          st_nxt.hold = HOLD_TICKS;
        end else if (p_start) begin
          st_nxt.st = ovpc_pkg::ST_RUNNING;
          st_nxt.evt = ovpc_pkg::MSG_START;
          st_nxt.hold = HOLD_TICKS;
        end else if (p_stop) begin
          st_nxt.evt = ovpc_pkg::MSG_STOP;
          st_nxt.hold = HOLD_TICKS;
        end
      end
      ovpc_pkg::ST_RUNNING: begin
        if (door) begin
          st_nxt.st = ovpc_pkg::ST_LOCKED;
          kill = 1'b1;
        end else if (fault) begin
          st_nxt.st = ovpc_pkg::ST_STOPPED;
          kill = 1'b1;
        end else if (p_stop) begin
          st_nxt.st = ovpc_pkg::ST_STOPPED;
          st_nxt.evt = ovpc_pkg::MSG_STOP;
          st_nxt.hold = HOLD_TICKS;
        end else if (p_mode || p_start) begin
          st_nxt.evt = ovpc_pkg::MSG_NOT_ALLOWED;
          st_nxt.hold = HOLD_TICKS;
        end
      end
      default: begin
        // a door fault stays latched until stop is pressed with door shut
        if (p_stop && !door) begin
          st_nxt.st = ovpc_pkg::ST_STOPPED;
          st_nxt.hold = 16'h0000;
        end else if (p_mode || p_start || p_stop) begin
          st_nxt.evt = ovpc_pkg::MSG_NOT_ALLOWED;
          st_nxt.hold = HOLD_TICKS;
        end
      end
    endcase

    // power stages follow the mode at zero-cross, faults cut at once
    st_nxt.run = (st_nxt.st == ovpc_pkg::ST_RUNNING);
    if (st_nxt.st == ovpc_pkg::ST_RUNNING) begin
      tgt = {st_r.mode[1], st_r.mode[0], 1'b1};
    end
    if (kill) begin
      st_nxt.fan = 1'b0;
      st_nxt.grill = 1'b0;
      st_nxt.micro = 1'b0;
    end else if (zc) begin
      st_nxt.fan = tgt[0];
      st_nxt.grill = tgt[1];
      st_nxt.micro = tgt[2];
    end

    // display priority: ac and adc faults, door, transient event, state
    if (st_r.ac_err) begin
      msg = ovpc_pkg::MSG_AC_ERROR;
    end else if (st_r.adc_err) begin
      msg = ovpc_pkg::MSG_ADC_ERROR;
    end else if (st_r.st == ovpc_pkg::ST_LOCKED) begin
      msg = door ? ovpc_pkg::MSG_ERROR : ovpc_pkg::MSG_STOP;
    end else if (st_r.st == ovpc_pkg::ST_STOPPED && door) begin
      msg = ovpc_pkg::MSG_OPEN;
    end else if (st_r.hold != 16'h0000) begin
      msg = st_r.evt;
    end else if (st_r.st == ovpc_pkg::ST_RUNNING) begin
      msg = ovpc_pkg::MSG_DIGITS;
    end
    st_nxt.seg = msg_segs(msg, st_r.mode, st_r.temp);
  end

  // single state register; reset leaves mode 1 and all stages off
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.mode <= ovpc_pkg::MODE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// [tb/ovpc_panel_model.sv]
// Purpose: far side of the panel: touch pads, converter, ac line
// Assumes: shares ref_clk with the controller
// Notes: hit and data lines carry junk outside their valid cycle
module ovpc_panel_model #(
  parameter int AC_HALF = 30
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bench controls
  input wire logic [15:0] keys,
  input wire logic ac_on,
  // controller side
  input wire logic touch_start,
  input wire logic [3:0] touch_chan,
  input wire logic adc_start,
  output logic touch_meas_done,
  output logic touch_hit,
  output logic adc_done,
  output logic [9:0] adc_data,
  output logic ac_line_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] adc_cnt;
  int ac_cnt;
  // touch answers next cycle, conversion four cycles after start
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      touch_meas_done <= 1'b0;
      touch_hit <= 1'b0;
      adc_done <= 1'b0;
      adc_data <= 10'h000;
      adc_cnt <= 2'h0;
      ac_cnt <= 0;
      ac_line_in <= 1'b0;
    end else begin
      touch_meas_done <= touch_start;
      touch_hit <= touch_start ? keys[touch_chan] : ~touch_hit;
      adc_done <= adc_cnt == 2'h1;
      adc_data <= (adc_cnt == 2'h1) ? 10'h200 : ~adc_data;
      adc_cnt <= adc_start ? 2'h3 : adc_cnt - 2'(adc_cnt != 2'h0);
      // square wave freezes when the line is lost
      if (ac_on) begin
        ac_cnt <= (ac_cnt == AC_HALF - 1) ? 0 : ac_cnt + 1;
        ac_line_in <= ac_line_in ^ (ac_cnt == AC_HALF - 1);
      end
    end
  end
endmodule

// [tb/ovpc_top_chk.sv]
// Purpose: port-level properties of the oven panel controller
// Assumes: one clock, reset async active high
// Notes: far side only answers real requests, so no stray done pulses
module ovpc_top_chk #(
  parameter logic [15:0] TICK_CYC = 16'h0014,
  parameter logic [15:0] SCAN_THR = 16'h0002
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // touch scan
  input wire logic touch_meas_done,
  input wire logic [3:0] touch_chan,
  input wire logic touch_start,
  // ac line and conversion
  input wire logic ac_line_in,
  input wire logic adc_done,
  input wire logic [9:0] adc_data,
  input wire logic adc_start,
  input wire logic [9:0] temp_value,
  // stages and display
  input wire logic fan_en,
  input wire logic grill_en,
  input wire logic micro_en,
  input wire logic [27:0] disp_seg
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [27:0] EROR = {ovpc_pkg::SEG_LE, ovpc_pkg::SEG_LR, ovpc_pkg::SEG_LO,
    ovpc_pkg::SEG_LR};
  logic [15:0] gap_r;
  logic seen_r;
  logic scan0;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // gain then drop eight bits, clamped to the display range
  function automatic logic [9:0] tcalc(input logic [9:0] d);
    logic [17:0] p;
    p = 18'(d) * 18'(ovpc_pkg::TEMP_GAIN);
    return (p[17:8] > ovpc_pkg::TEMP_MAX) ? ovpc_pkg::TEMP_MAX : p[17:8];
  endfunction
  // cycles since the last scan began; first scan only arms the check
  assign scan0 = touch_start && touch_chan == 4'h0;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      gap_r <= scan0 ? 16'h0001 : gap_r + 16'h0001;
      seen_r <= seen_r || scan0;
    end
  end
  sequence s_next(logic [3:0] c);
    touch_start && touch_chan == c + 4'h1;
  endsequence
  // an ac edge reached the pin a few cycles back (sync delay)
  sequence s_ac_moved;
    $past(ac_line_in, 1) != $past(ac_line_in, 8);
  endsequence
  chk_touch_next: assert property (
    touch_meas_done && touch_chan != 4'hf |=> s_next($past(touch_chan)))
    else $error("touch channel did not advance");
  chk_touch_end: assert property (
    touch_meas_done && touch_chan == 4'hf |=> !touch_start)
    else $error("scan ran past the last channel");
  chk_scan_period: assert property (
    scan0 && seen_r |-> gap_r == 16'(TICK_CYC * SCAN_THR))
    else $error("scan interval wrong");
  chk_adc_pulse: assert property (
    adc_start |=> !adc_start [*2])
    else $error("conversion start not a single pulse");
  chk_temp_calc: assert property (
    adc_done |-> ##2 temp_value == tcalc($past(adc_data, 2)))
    else $error("temperature not taken from sample");
  chk_fan_first: assert property (
    grill_en || micro_en |-> fan_en)
    else $error("grill or microwave without fan");
  chk_stage_hold: assert property (
    fan_en && $past(fan_en) |-> $stable({micro_en, grill_en}))
    else $error("stage set changed while running");
  chk_stage_zc: assert property (
    $rose(fan_en) |-> s_ac_moved)
    else $error("stages switched away from a zero crossing");
  chk_error_off: assert property (
    disp_seg == EROR |-> !(fan_en || grill_en || micro_en))
    else $error("stages on while door error shown");
  chk_reset_mode: assert property (
    $fell(reset) |-> !(grill_en || micro_en))
    else $error("grill or microwave on after reset");
endmodule
bind ovpc_top ovpc_top_chk #(.TICK_CYC(TICK_CYC), .SCAN_THR(SCAN_THR)) u_chk (
  .ref_clk, .reset, .touch_meas_done, .touch_chan, .touch_start, .ac_line_in,
  .adc_done, .adc_data, .adc_start, .temp_value, .fan_en, .grill_en, .micro_en,
  .disp_seg);

// [tb/ovpc_top_tb.sv]
// Purpose: scenario bench for the oven panel controller
// Assumes: shortened tick and timeout counts, prompt far side
// Notes: keys confirm after three scans, so a press lasts ~200 cycles
module ovpc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] P_TICK = 16'h0014, P_SCAN = 16'h0002, P_ADC = 16'h0005;
  localparam logic [15:0] P_SMP = 16'h0001, P_HOLD = 16'h0003;
  localparam logic [12:0] P_RND = 13'h0002;
  localparam logic [22:0] P_AC = 23'h0000c8;
  localparam logic [20:0] OPT = {ovpc_pkg::SEG_UO, ovpc_pkg::SEG_UP, ovpc_pkg::SEG_UT};
  localparam logic [27:0] NORL = {ovpc_pkg::SEG_LN, ovpc_pkg::SEG_LO, ovpc_pkg::SEG_LR,
    ovpc_pkg::SEG_LL};
  localparam logic [27:0] STAR = {ovpc_pkg::SEG_US, ovpc_pkg::SEG_UT, ovpc_pkg::SEG_UA,
    ovpc_pkg::SEG_LR};
  localparam logic [27:0] STOP = {ovpc_pkg::SEG_US, ovpc_pkg::SEG_UT, ovpc_pkg::SEG_UO,
    ovpc_pkg::SEG_UP};
  localparam logic [27:0] NOTA = {ovpc_pkg::SEG_LN, ovpc_pkg::SEG_LO, ovpc_pkg::SEG_UT,
    ovpc_pkg::SEG_UA};
  localparam logic [27:0] EROR = {ovpc_pkg::SEG_LE, ovpc_pkg::SEG_LR, ovpc_pkg::SEG_LO,
    ovpc_pkg::SEG_LR};
  localparam logic [27:0] OPEN = {ovpc_pkg::SEG_UO, ovpc_pkg::SEG_UP, ovpc_pkg::SEG_UE,
    ovpc_pkg::SEG_LN};
  logic ref_clk, reset, door_open_in, ac_on, touch_meas_done, touch_hit, adc_done;
  logic ac_line_in, touch_start, adc_start, fan_en, grill_en, micro_en;
  logic run_active, ac_error, adc_error;
  logic [15:0] keys, line_clock;
  logic [3:0] touch_chan;
  logic [9:0] adc_data, temp_value;
  logic [27:0] disp_seg;
  logic [22:0] line_period;
  int bad_count = 0;
  int n_checks = 0;
  ovpc_top #(.TICK_CYC(P_TICK), .RND_UNIT_CYC(P_RND), .AC_TIMEOUT_CYC(P_AC), .SCAN_THR(P_SCAN),
    .ADC_THR(P_ADC), .SMP_THR(P_SMP), .HOLD_TICKS(P_HOLD)) u_dut (.ref_clk, .reset,
    .touch_meas_done, .touch_hit, .touch_chan, .touch_start, .door_open_in, .ac_line_in,
    .adc_done, .adc_data, .adc_start, .fan_en, .grill_en, .micro_en, .disp_seg, .run_active,
    .ac_error, .adc_error, .line_period, .line_clock, .temp_value);
  ovpc_panel_model u_far (.ref_clk, .reset, .keys, .ac_on, .touch_start, .touch_chan,
    .adc_start, .touch_meas_done, .touch_hit, .adc_done, .adc_data, .ac_line_in);
  // 40 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // bench drives and samples 2 ns after the edge, clear of any race
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [27:0] stg();
    return 28'({micro_en, grill_en, fan_en});
  endfunction
  // messages are held only briefly, so poll for them each cycle
  task automatic show(input logic [27:0] exp);
    for (int i = 0; i < 600 && disp_seg !== exp; i++) cyc(1);
    check("display", disp_seg, exp);
  endtask
  task automatic press(input int k, input logic [27:0] exp);
    keys[k] = 1'b1;
    show(exp);
    keys[k] = 1'b0;
    cyc(200);
  endtask
  task automatic idle_key(input int k, input logic [27:0] exp);
    keys[k] = 1'b1;
    cyc(200);
    check("display", disp_seg, exp);
    check("stages", stg(), 28'h0);
    keys[k] = 1'b0;
    cyc(200);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_keys();
    int ks[4] = '{0, 7, 11, 15};
    check("stages", stg(), 28'h0);
    show(NORL);
    foreach (ks[i]) idle_key(ks[i], NORL);
    for (int m = 1; m <= 5; m++) press(8, {OPT, ovpc_pkg::SEG_DIGIT[m % 4 + 1]});
    $display("keys done");
  endtask
  task automatic t_run();
    press(9, STAR);
    check("stages", stg(), 28'h3);
    check("display", disp_seg, {ovpc_pkg::SEG_BLANK, ovpc_pkg::SEG_DIGIT[3],
      ovpc_pkg::SEG_DIGIT[8], ovpc_pkg::SEG_DIGIT[4]});
    press(8, NOTA);
    press(9, NOTA);
    check("stages", stg(), 28'h3);
    press(10, STOP);
    check("stages", stg(), 28'h0);
    $display("run done");
  endtask
  task automatic t_door();
    door_open_in = 1'b1;
    show(OPEN);
    idle_key(9, OPEN);
    door_open_in = 1'b0;
    show(NORL);
    press(9, STAR);
    door_open_in = 1'b1;
    show(EROR);
    check("stages", stg(), 28'h0);
    door_open_in = 1'b0;
    show(STOP);
    press(10, NORL);
    check("running", 28'(run_active), 28'h0);
    $display("door done");
  endtask
  task automatic t_line();
    logic [15:0] lc = line_clock;
    check("period", 28'(line_period), 28'h000001e);
    check("temp", 28'(temp_value), 28'h0000180);
    cyc(60);
    check("edges", 28'(line_clock - lc), 28'h2);
    ac_on = 1'b0;
    cyc(260);
    check("ac fault", 28'(ac_error), 28'h1);
    check("display", disp_seg, {ovpc_pkg::SEG_UA, ovpc_pkg::SEG_UC, ovpc_pkg::SEG_LE,
      ovpc_pkg::SEG_LR});
    ac_on = 1'b1;
    cyc(60);
    check("ac fault", 28'(ac_error), 28'h0);
    $display("line done");
  endtask
  // main sequence
  initial begin
    reset = 1'b1;
    door_open_in = 1'b0;
    ac_on = 1'b1;
    keys = 16'h0000;
    cyc(3);
    reset = 1'b0;
    cyc(2);
    t_keys();
    t_run();
    t_door();
    t_line();
    stop_test();
  end
  // watchdog, well beyond the expected run of ~6500 cycles
  initial begin
    repeat (30000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
endmodule
